// ===== mise_core.sv
// Decode and execute for a subset of the 12-bit instruction set
`timescale 1ns/1ns
`include "mise_params.svh"
module mise_core (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic [11:0] instr,
    input  wire logic        instr_valid,
    input  wire logic [7:0]  file_rdata,
    input  wire logic [10:0] stack_top,
    input  wire logic [7:0]  status_in,
    output logic      [10:0] pc,
    output logic      [4:0]  file_addr,
    output logic      [7:0]  file_wdata,
    output logic             file_we,
    output logic      [7:0]  acc,
    output logic      [7:0]  status,
    output logic      [7:0]  config_reg,
    output logic      [7:0]  dir_a,
    output logic      [7:0]  dir_b,
    output logic      [7:0]  dir_c,
    output logic             stack_pop,
    output logic             flush,
    output logic             illegal
);
    ////////////////////////////////////////////////////////////////
    // Decode
    mise_pkg::mise_state_type state;
    logic       jump_op;
    logic       increment_op;
    logic       increment_skip_zero_op;
    logic       move_acc_to_file_op;
    logic       no_operation_op;
    logic       config_op;
    logic       return_literal_op;
    logic       subtract_op;
    logic       nibble_swap_op;
    logic       direction_load_op;
    logic       dir_ok;
    logic       dest_file;
    logic [7:0] inc_val;
    logic [8:0] sub_val;
    logic [4:0] sub_lo;
    logic [7:0] swap_val;
    logic       run;

    function automatic logic [7:0] mise_plus_one(input logic [7:0] v);
        mise_plus_one = v + 8'h01;
    endfunction : mise_plus_one

    assign run                    = ce && instr_valid && (state == mise_pkg::MISE_EXEC);
    assign jump_op                = instr[11:9] == 3'h5;
    assign return_literal_op      = instr[11:8] == 4'h8;
    assign increment_op           = instr[11:6] == 6'h0a;
    assign increment_skip_zero_op = instr[11:6] == 6'h0f;
    assign nibble_swap_op         = instr[11:6] == 6'h0e;
    assign subtract_op            = instr[11:6] == 6'h02;
    assign move_acc_to_file_op    = instr[11:5] == 7'h01;
    assign config_op              = instr == `MISE_CONFIG_WORD;
    assign no_operation_op        = instr == `MISE_NOP_WORD;
    assign direction_load_op      = instr[11:3] == 9'h000 && instr[2:0] != 3'h0 && instr[2:0] != 3'h2;
    assign dir_ok                 = instr[2:0] >= `MISE_DIR_FIRST && instr[2:0] <= `MISE_DIR_LAST;
    assign dest_file              = instr[5];
    assign inc_val                = mise_plus_one(file_rdata);
    assign sub_val                = {1'b0, file_rdata} + {1'b0, ~acc} + 9'h001;
    assign sub_lo                 = {1'b0, file_rdata[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    assign swap_val               = {file_rdata[3:0], file_rdata[7:4]};

    ////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= mise_pkg::MISE_EXEC;
            flush <= 1'b0;
        end else if (ce) begin
            case (state)
                mise_pkg::MISE_EXEC: begin
                    flush <= 1'b0;
                    if (run && (jump_op || return_literal_op)) begin
                        state <= mise_pkg::MISE_FLUSH;
                        flush <= 1'b1;
                    end else if (run && increment_skip_zero_op && inc_val == 8'h00) begin
                        state <= mise_pkg::MISE_FLUSH;
                        flush <= 1'b1;
                    end
                end
                mise_pkg::MISE_FLUSH: begin
                    state <= mise_pkg::MISE_EXEC;
                    flush <= 1'b0;
                end
                default: begin
                    state <= mise_pkg::MISE_EXEC;
                    flush <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Program counter
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pc        <= `MISE_PC_RST;
            stack_pop <= 1'b0;
        end else if (ce) begin
            stack_pop <= 1'b0;
            if (run && jump_op) begin
                pc <= {status_in[`MISE_PAGE_HI:`MISE_PAGE_LO], instr[8:0]};
            end else if (run && return_literal_op) begin
                pc        <= stack_top;
                stack_pop <= 1'b1;
            end else if (state == mise_pkg::MISE_FLUSH || run) begin
                pc <= pc + 11'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Accumulator and file write
    always_ff @(posedge clock) begin
        if (!nrst) begin
            acc        <= 8'h00;
            file_we    <= 1'b0;
            file_addr  <= 5'h00;
            file_wdata <= 8'h00;
        end else if (ce) begin
            file_we   <= 1'b0;
            file_addr <= instr[4:0];
            if (run && (increment_op || increment_skip_zero_op)) begin
                if (dest_file) begin
                    file_we    <= 1'b1;
                    file_wdata <= inc_val;
                end else begin
                    acc <= inc_val;
                end
            end else if (run && nibble_swap_op) begin
                if (dest_file) begin
                    file_we    <= 1'b1;
                    file_wdata <= swap_val;
                end else begin
                    acc <= swap_val;
                end
            end else if (run && subtract_op) begin
                if (dest_file) begin
                    file_we    <= 1'b1;
                    file_wdata <= sub_val[7:0];
                end else begin
                    acc <= sub_val[7:0];
                end
            end else if (run && move_acc_to_file_op) begin
                file_we    <= 1'b1;
                file_wdata <= acc;
            end else if (run && return_literal_op) begin
                acc <= instr[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status flags
    always_ff @(posedge clock) begin
        if (!nrst) begin
            status <= `MISE_STATUS_RST;
        end else if (ce) begin
            if (run && increment_op) begin
                status                <= status_in;
                status[`MISE_FLAG_Z]  <= inc_val == 8'h00;
            end else if (run && subtract_op) begin
                status                <= status_in;
                status[`MISE_FLAG_C]  <= sub_val[8];
                status[`MISE_FLAG_DC] <= sub_lo[4];
                status[`MISE_FLAG_Z]  <= sub_val[7:0] == 8'h00;
            end else begin
                status <= status_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Configuration and direction registers
    always_ff @(posedge clock) begin
        if (!nrst) begin
            config_reg <= `MISE_CONFIG_RST;
            dir_a      <= `MISE_DIR_RST;
            dir_b      <= `MISE_DIR_RST;
            dir_c      <= `MISE_DIR_RST;
            illegal    <= 1'b0;
        end else if (ce) begin
            illegal <= 1'b0;
            if (run && config_op) begin
                config_reg <= acc;
            end else if (run && direction_load_op) begin
                case (instr[2:0])
                    3'h5: dir_a <= acc;
                    3'h6: dir_b <= acc;
                    3'h7: dir_c <= acc;
                    default: illegal <= !dir_ok;
                endcase
            end
        end
    end
endmodule : mise_core

// ===== mise_core_monitor.sv
// Assertions on the execution block ports
`timescale 1ns/1ns
module mise_core_monitor (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        ce,
    input wire logic        instr_valid,
    input wire logic        file_we,
    input wire logic        stack_pop,
    input wire logic        flush,
    input wire logic        illegal,
    input wire logic [11:0] instr,
    input wire logic [10:0] stack_top,
    input wire logic [10:0] pc,
    input wire logic [7:0]  file_rdata,
    input wire logic [7:0]  file_wdata,
    input wire logic [7:0]  status_in,
    input wire logic [7:0]  acc,
    input wire logic [7:0]  status,
    input wire logic [7:0]  config_reg,
    input wire logic [7:0]  dir_a
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic tk;
    logic hold_ok;
    assign tk      = ce && instr_valid && !flush;
    assign hold_ok = tk || !ce;
    ////////////////////////////////////////////////////////////
    AST_JUMP: assert property (tk && instr[11:9] == 3'h5 |=> flush && pc == {$past(status_in[6:5]), $past(instr[8:0])})
        else $error("jump target wrong");
    AST_INC: assert property (tk && instr[11:5] == 7'h14 |=> acc == $past(file_rdata) + 8'h01 && !file_we)
        else $error("increment result wrong");
    AST_SKIP: assert property (tk && instr[11:6] == 6'h0f |=> flush == ($past(file_rdata) == 8'hff) && status == $past(status_in))
        else $error("skip wrong");
    AST_MOVE: assert property (tk && instr[11:5] == 7'h01 |=> file_we && file_wdata == $past(acc) ##1 (!file_we || $past(hold_ok)))
        else $error("move wrong");
    AST_CONFIG: assert property (tk && instr == 12'h002 |=> config_reg == $past(acc) && !flush)
        else $error("config load wrong");
    AST_RET: assert property (tk && instr[11:8] == 4'h8 |=> acc == $past(instr[7:0]) && pc == $past(stack_top) && stack_pop ##1 (!stack_pop || !$past(ce)))
        else $error("return wrong");
    AST_SWAP: assert property (tk && instr[11:5] == 7'h1d |=> file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
        else $error("swap wrong");
    AST_DIR: assert property (tk && instr[11:3] == 9'h000 && instr[2:0] inside {3'h1, 3'h3, 3'h4} |=> illegal && $stable(dir_a))
        else $error("bad direction field accepted");
    AST_SUB: assert property (tk && instr[11:5] == 7'h04 |=> acc == $past(file_rdata) - $past(acc) && status[0] == ($past(file_rdata) >= $past(acc)))
        else $error("subtract wrong");
    AST_NOP: assert property (tk && instr == 12'h000 |=> $stable(acc) && !file_we && !flush && !illegal)
        else $error("no-operation changed state");
    cover property (tk && instr[11:9] == 3'h5);
    cover property (flush && $past(instr[11:6]) == 6'h0f);
    cover property (illegal);
endmodule : mise_core_monitor
bind mise_core mise_core_monitor i_mon (.clock, .nrst, .ce, .instr_valid, .file_we, .stack_pop, .flush, .illegal,
    .instr, .stack_top, .pc, .file_rdata, .file_wdata, .status_in, .acc, .status, .config_reg, .dir_a);

// ===== mise_core_tb_top.sv
// Testbench for the execution block
`timescale 1ns/1ns
`include "mise_params.svh"
module mise_core_tb_top;
    logic        clock, nrst, ce, instr_valid, file_we, stack_pop, flush, illegal;
    logic [11:0] instr;
    logic [10:0] stack_top, pc;
    logic [7:0]  file_rdata, status_in, acc, status, config_reg, dir_a, dir_b, dir_c, file_wdata, wa;
    logic [4:0]  file_addr;
    logic [2:0]  sf;
    logic [1:0]  page;
    logic [20:0] seen1;
    int          n_errors, tests_run;
    mise_core i_mise_core (.clock, .nrst, .ce, .instr, .instr_valid, .file_rdata, .stack_top, .status_in, .pc,
        .file_addr, .file_wdata, .file_we, .acc, .status, .config_reg, .dir_a, .dir_b, .dir_c, .stack_pop, .flush,
        .illegal);
    mise_fetch_model i_mise_fetch_model (.clock, .file_we, .rd_addr(instr[4:0]), .file_addr, .file_wdata, .status,
        .page, .file_rdata, .status_in, .stack_top);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    task automatic run(input logic [11:0] w, input logic fl);
        @(posedge clock);
        instr <= w;
        instr_valid <= 1'b1;
        @(posedge clock);
        instr <= 12'h2a0 | 12'($urandom_range(31));
        instr_valid <= fl;
        #1;
        seen1 = {pc, stack_pop, file_we, file_wdata};
        chk(flush, fl);
        if (fl) begin
            @(posedge clock);
            instr_valid <= 1'b0;
            #1;
            chk({flush, file_we}, 2'b00);
        end
    endtask : run
    task automatic ret(input logic [7:0] k);
        run({4'h8, k}, 1'b1);
        wa = k;
    endtask : ret
    task automatic op(input logic [11:0] w);
        logic [7:0] fv, r;
        logic [2:0] nf;
        @(posedge clock);
        #1;
        fv = i_mise_fetch_model.mem[w[4:0]];
        nf = sf;
        r = fv + 8'h01;
        if (w[11:6] == 6'h0e) begin
            r = {fv[3:0], fv[7:4]};
        end else if (w[11:6] == 6'h02) begin
            r = fv - wa;
            nf[1:0] = {fv[3:0] >= wa[3:0], fv >= wa};
        end
        if (w[11:6] == 6'h0a || w[11:6] == 6'h02) begin
            nf[2] = (r == 8'h00);
        end
        run(w, w[11:6] == 6'h0f && r == 8'h00);
        chk(status[2:0], nf);
        chk(w[5] ? seen1[8:0] : {seen1[8], acc}, {w[5], r});
        sf = nf;
        if (!w[5]) begin
            wa = r;
        end
    endtask : op
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        logic [5:0] pre [4] = '{6'h0a, 6'h0f, 6'h0e, 6'h02};
        logic [8:0] k9;
        logic [18:0] snap;
        n_errors = 0;
        tests_run = 0;
        {nrst, ce, instr, instr_valid, page, wa, sf} = {2'b01, 12'h000, 1'b0, 2'h0, 8'h00, 3'h0};
        void'($urandom(32'hc2a2912b));
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        #1;
        chk({pc, acc, status, config_reg, dir_a}, {`MISE_PC_RST, 8'h00, `MISE_STATUS_RST, 8'hff, `MISE_DIR_RST});
        for (int i = 0; i < 32; i++) begin
            ret(i == 7 ? 8'hff : 8'($urandom));
            chk({seen1[20:9], acc}, {11'h3a5, 1'b1, wa});
            run({7'h01, 5'(i)}, 1'b0);
            chk({file_we, file_addr, file_wdata}, {1'b1, 5'(i), wa});
        end
        op(12'h3c7);
        for (int f = 0; f < 8; f++) begin
            ret(8'($urandom));
            run(12'(f), 1'b0);
            chk(illegal, f inside {1, 3, 4});
            chk(f == 5 ? dir_a : f == 6 ? dir_b : f == 7 ? dir_c : f == 2 ? config_reg : wa, wa);
            chk(acc, wa);
        end
        for (int n = 0; n < 300; n++) begin
            op({pre[$urandom_range(3)], 1'($urandom), 5'($urandom)});
            if (n % 20 == 0) begin
                k9 = 9'($urandom);
                page <= 2'($urandom);
                run({3'h5, k9}, 1'b1);
                chk(seen1[20:10], {page, k9});
            end
            if (n % 50 == 25) begin
                snap = {pc, acc};
                @(posedge clock);
                ce          <= 1'b0;
                instr       <= 12'h8c3;
                instr_valid <= 1'b1;
                repeat (3) @(posedge clock);
                #1;
                chk({pc, acc, stack_pop, flush}, {snap, 2'b00});
                @(posedge clock);
                ce          <= 1'b1;
                instr_valid <= 1'b0;
            end
        end
        tally_and_finish();
    end
endmodule : mise_core_tb_top

// ===== mise_fetch_model.sv
// Register file and stack partner of the execution block
`timescale 1ns/1ns
module mise_fetch_model (
    input wire logic        clock,
    input wire logic        file_we,
    input wire logic [4:0]  rd_addr,
    input wire logic [4:0]  file_addr,
    input wire logic [7:0]  file_wdata,
    input wire logic [7:0]  status,
    input wire logic [1:0]  page,
    output logic     [7:0]  file_rdata,
    output logic     [7:0]  status_in,
    output logic     [10:0] stack_top
);
    logic [7:0] mem [32];
    assign file_rdata = mem[rd_addr];
    assign status_in  = {status[7], page, status[4:0]};
    assign stack_top  = 11'h3a5;
    always @(posedge clock) begin
        if (file_we) begin
            mem[file_addr] <= file_wdata;
        end
    end
endmodule : mise_fetch_model

// ===== mise_params.svh
// Constants for the instruction subset execution block
// Contract
// - Jump loads pc 8..0 from literal, 10..9 from status 6..5; two cycles.
// - Increment adds one to file, destination by d bit, updates zero flag only.
// - Increment-skip-zero increments without flags; zero result flushes next word, two cycles.
// - Move accumulator to addressed file register, one cycle, no flags.
// - Configuration load copies accumulator to configuration register, one cycle, no flags.
// - Return literal loads accumulator with literal, pc from stack top; two cycles.
// - Nibble swap exchanges file nibbles to destination by d bit, no flags.
// - Direction load accepts fields 5,6,7 only, copies accumulator to that direction register.
`ifndef MISE_PARAMS_SVH
`define MISE_PARAMS_SVH
`define MISE_FLAG_C        0
`define MISE_FLAG_DC       1
`define MISE_FLAG_Z        2
`define MISE_PAGE_LO       5
`define MISE_PAGE_HI       6
`define MISE_STATUS_RST    8'h18
`define MISE_CONFIG_RST    8'hff
`define MISE_DIR_RST       8'hff
`define MISE_PC_RST        11'h7ff
`define MISE_DIR_FIRST     3'h5
`define MISE_DIR_LAST      3'h7
`define MISE_CONFIG_WORD   12'h002
`define MISE_NOP_WORD      12'h000
`endif

// ===== mise_pkg.sv
// Types for the instruction subset execution block
package mise_pkg;
    typedef enum logic [2:0] {
        MISE_EXEC  = 3'b001,
        MISE_FLUSH = 3'b010,
        MISE_IDLE  = 3'b100
    } mise_state_type;
endpackage : mise_pkg
